// >>> design/wiper_pkg.sv
package wiper_pkg;
    localparam int WORD_BITS = 16;
    localparam int WIPER_BITS = 6;
    localparam int CHANNELS = 4;
    localparam int STORE_ENTRIES = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam logic [5:0] WIPER_MIDSCALE = 6'h20;
    localparam logic [7:0] STORE_RESET = 8'h20;
    localparam logic [7:0] USER_RESET = 8'hFF;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAVE_TIME_MS = 25;
    localparam int SAVE_CYCLES = (SAVE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RESTORE_ONE = 4'h1;
    localparam logic [3:0] CMD_SAVE_ONE = 4'h2;
    localparam logic [3:0] CMD_STORE_WRITE = 4'h3;
    localparam logic [3:0] CMD_DEC_SHIFT_ONE = 4'h4;
    localparam logic [3:0] CMD_DEC_SHIFT_ALL = 4'h5;
    localparam logic [3:0] CMD_DEC_STEP_ONE = 4'h6;
    localparam logic [3:0] CMD_DEC_STEP_ALL = 4'h7;
    localparam logic [3:0] CMD_RELOAD_ALL = 4'h8;
    localparam logic [3:0] CMD_READ_STORE = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER = 4'hA;
    localparam logic [3:0] CMD_WRITE_WIPER = 4'hB;
    localparam logic [3:0] CMD_INC_SHIFT_ONE = 4'hC;
    localparam logic [3:0] CMD_INC_SHIFT_ALL = 4'hD;
    localparam logic [3:0] CMD_INC_STEP_ONE = 4'hE;
    localparam logic [3:0] CMD_INC_STEP_ALL = 4'hF;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } command_word_type;

    typedef struct packed {
        logic clk;
        logic cs_n;
        logic serial_in;
    } link_in_type;
endpackage

// >>> design/wiper_step_unit.sv
`timescale 1ns/1ps
module wiper_step_unit
    import wiper_pkg::*;
#(
    parameter int WIDTH = WIPER_BITS
) (
    // Operand and operation
    input wire logic [WIDTH-1:0] i_value,
    input wire logic i_up,
    input wire logic i_shift,
    // Result
    output logic [WIDTH-1:0] o_value
);
    always_comb begin
        o_value = i_value;
        if (i_shift && i_up) begin
            o_value = i_value[WIDTH-1] ? {WIDTH{1'b1}} : {i_value[WIDTH-2:0], 1'b0};
        end else if (i_shift) begin
            o_value = {1'b0, i_value[WIDTH-1:1]};
        end else if (i_up) begin
            if (i_value != {WIDTH{1'b1}}) begin
                o_value = i_value + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end else if (i_value != {WIDTH{1'b0}}) begin
            o_value = i_value - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // wiper_step_unit

// >>> design/serial_wiper_command_control.sv
`timescale 1ns/1ps
module serial_wiper_command_control
    import wiper_pkg::*;
#(
    parameter int SAVE_WAIT = SAVE_CYCLES,
    parameter int CH = CHANNELS
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Serial link
    input wire logic i_serial_clk,
    input wire logic i_chip_select_n,
    input wire logic i_serial_in,
    output logic o_serial_out_open_drain,
    output logic o_serial_out_oe,
    // Control pins
    input wire logic i_preset_reload_pin_n,
    input wire logic i_write_protect_n,
    // Status pins
    output logic o_ready_out,
    output logic o_ready_oe,
    output logic o_low_power,
    // Wiper settings
    output logic [CH*WIPER_BITS-1:0] o_wiper_setting_register
);
    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_IDLE = 4'h2,
        ST_SAVE = 4'h4,
        ST_DONE = 4'h8
    } phase_type;

    typedef struct packed {
        link_in_type sync1;
        link_in_type sync2;
        link_in_type last;
        logic preset_sync1;
        logic preset_sync2;
        logic preset_last;
        logic protect_sync1;
        logic protect_sync2;
        logic [WORD_BITS-1:0] shift;
        logic [4:0] bit_count;
        logic [WORD_BITS-1:0] out_shift;
        logic sdo_bit;
        logic [3:0] repeat_cmd;
        logic [3:0] repeat_addr;
        logic repeat_valid;
        logic read_pending;
        logic [CH-1:0][WIPER_BITS-1:0] wiper;
        logic [STORE_ENTRIES-1:0][7:0] store;
        logic [31:0] wait_count;
        logic [3:0] save_addr;
        logic [7:0] save_data;
        logic ready;
        logic low_power;
        logic step_apply;
        logic step_apply_all;
        logic [1:0] step_ch;
        phase_type phase;
    } state_type;

    state_type state;
    state_type next_state;
    logic [CH-1:0][WIPER_BITS-1:0] stepped;
    logic step_up;
    logic step_shift;

    always_comb begin
        step_up = state.repeat_cmd[3];
        step_shift = ~state.repeat_cmd[1];
    end

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_step
            wiper_step_unit #(.WIDTH(WIPER_BITS)) u_step (
                .i_value(state.wiper[g]),
                .i_up(step_up),
                .i_shift(step_shift),
                .o_value(stepped[g])
            );
        end
    endgenerate

    always_comb begin
        command_word_type word;
        logic clk_rise;
        logic clk_fall;
        logic cs_rise;
        logic cs_fall;
        logic [3:0] cmd;
        logic [1:0] ch;
        logic run_step;
        logic step_all;
        logic [WORD_BITS-1:0] echo_src;
        word = '0;
        echo_src = '0;
        cmd = '0;
        ch = '0;
        run_step = 1'b0;
        step_all = 1'b0;
        next_state = state;
        next_state.sync1 = '{clk: i_serial_clk, cs_n: i_chip_select_n, serial_in: i_serial_in};
        next_state.sync2 = state.sync1;
        next_state.last = state.sync2;
        next_state.preset_sync1 = i_preset_reload_pin_n;
        next_state.preset_sync2 = state.preset_sync1;
        next_state.preset_last = state.preset_sync2;
        next_state.protect_sync1 = i_write_protect_n;
        next_state.protect_sync2 = state.protect_sync1;
        clk_rise = state.sync2.clk & ~state.last.clk;
        clk_fall = ~state.sync2.clk & state.last.clk;
        cs_rise = state.sync2.cs_n & ~state.last.cs_n;
        cs_fall = ~state.sync2.cs_n & state.last.cs_n;
        word = state.shift;
        cmd = word.cmd;
        ch = word.addr[1:0];
        if (cs_fall) begin
            next_state.bit_count = '0;
            next_state.ready = 1'b0;
            next_state.read_pending = 1'b0;
        end
        if (!state.sync2.cs_n && clk_rise && state.phase != ST_SAVE) begin
            next_state.shift = {state.shift[WORD_BITS-2:0], state.sync2.serial_in};
            if (state.bit_count != 5'h1F) begin
                next_state.bit_count = state.bit_count + 5'h01;
            end
        end
        echo_src = state.read_pending ? state.out_shift : state.shift;
        // First bit stands from select fall; later bits move on falls after a rise
        if (cs_fall) begin
            next_state.sdo_bit = echo_src[WORD_BITS-1];
            next_state.out_shift = {echo_src[WORD_BITS-2:0], 1'b0};
        end else if (!state.sync2.cs_n && clk_fall && state.bit_count != 5'h00) begin
            next_state.sdo_bit = state.out_shift[WORD_BITS-1];
            next_state.out_shift = {state.out_shift[WORD_BITS-2:0], 1'b0};
        end
        case (state.phase)
            ST_INIT: begin
                for (int i = 0; i < CH; i++) begin
                    next_state.wiper[i] = state.store[i][WIPER_BITS-1:0];
                end
                next_state.phase = ST_IDLE;
            end
            ST_IDLE: begin
                if (cs_rise && state.bit_count >= 5'(WORD_BITS)) begin
                    next_state.low_power = 1'b0;
                    next_state.repeat_valid = 1'b0;
                    case (cmd)
                        CMD_NOP: begin
                            next_state.low_power = 1'b1;
                        end
                        CMD_RESTORE_ONE: begin
                            next_state.wiper[ch] = state.store[ch][WIPER_BITS-1:0];
                        end
                        CMD_SAVE_ONE: begin
                            next_state.save_addr = {2'b00, ch};
                            next_state.save_data = {2'b00, state.wiper[ch]};
                            next_state.wait_count = '0;
                            next_state.phase = ST_SAVE;
                        end
                        CMD_STORE_WRITE: begin
                            next_state.save_addr = word.addr;
                            next_state.save_data = word.data;
                            next_state.wait_count = '0;
                            next_state.phase = ST_SAVE;
                        end
                        CMD_RELOAD_ALL: begin
                            for (int i = 0; i < CH; i++) begin
                                next_state.wiper[i] = state.store[i][WIPER_BITS-1:0];
                            end
                            next_state.ready = 1'b1;
                        end
                        CMD_READ_STORE: begin
                            next_state.out_shift = {state.shift[15:8], state.store[word.addr]};
                            next_state.read_pending = 1'b1;
                            next_state.ready = 1'b1;
                        end
                        CMD_READ_WIPER: begin
                            next_state.out_shift = {state.shift[15:8], 2'b00, state.wiper[ch]};
                            next_state.read_pending = 1'b1;
                            next_state.ready = 1'b1;
                        end
                        CMD_WRITE_WIPER: begin
                            if (state.protect_sync2) begin
                                next_state.wiper[ch] = word.data[WIPER_BITS-1:0];
                            end
                        end
                        default: begin
                            next_state.repeat_cmd = cmd;
                            next_state.repeat_addr = word.addr;
                            next_state.repeat_valid = 1'b1;
                            run_step = 1'b1;
                        end
                    endcase
                end else if (cs_rise && state.repeat_valid) begin
                    run_step = 1'b1;
                end
            end
            ST_SAVE: begin
                if (state.wait_count >= 32'(SAVE_WAIT - 1)) begin
                    if (state.protect_sync2) begin
                        next_state.store[state.save_addr] = state.save_data;
                    end
                    next_state.phase = ST_DONE;
                end else begin
                    next_state.wait_count = state.wait_count + 32'h1;
                end
            end
            ST_DONE: begin
                next_state.ready = 1'b1;
                next_state.phase = ST_IDLE;
            end
            default: begin
                next_state.phase = ST_IDLE;
            end
        endcase
        // Repeat executes with the command bits just latched on a fresh word
        if (run_step && state.protect_sync2) begin
            step_all = (cs_rise && state.bit_count >= 5'(WORD_BITS)) ? cmd[0]
                                                                      : state.repeat_cmd[0];
            if (cs_rise && state.bit_count >= 5'(WORD_BITS)) begin
                next_state.repeat_cmd = cmd;
            end
        end
        // Stepper result lands one cycle after the command is latched
        next_state.step_apply = run_step && state.protect_sync2 && state.preset_sync2;
        next_state.step_apply_all = step_all;
        next_state.step_ch = (cs_rise && state.bit_count >= 5'(WORD_BITS)) ? ch
                                                                           : state.repeat_addr[1:0];
        if (state.step_apply) begin
            for (int i = 0; i < CH; i++) begin
                if (state.step_apply_all || state.step_ch == 2'(i)) begin
                    next_state.wiper[i] = stepped[i];
                end
            end
        end
        if (!state.preset_sync2) begin
            for (int i = 0; i < CH; i++) begin
                next_state.wiper[i] = WIPER_MIDSCALE;
            end
        end else if (!state.preset_last) begin
            for (int i = 0; i < CH; i++) begin
                next_state.wiper[i] = state.store[i][WIPER_BITS-1:0];
            end
            next_state.ready = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
            state.phase <= ST_INIT;
            for (int i = 0; i < STORE_ENTRIES; i++) begin
                state.store[i] <= (i < CHANNELS) ? STORE_RESET : USER_RESET;
            end
            state.sync1 <= '{clk: 1'b0, cs_n: 1'b1, serial_in: 1'b0};
            state.sync2 <= '{clk: 1'b0, cs_n: 1'b1, serial_in: 1'b0};
            state.last <= '{clk: 1'b0, cs_n: 1'b1, serial_in: 1'b0};
            state.preset_sync1 <= 1'b1;
            state.preset_sync2 <= 1'b1;
            state.preset_last <= 1'b1;
            state.protect_sync1 <= 1'b1;
            state.protect_sync2 <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        o_serial_out_open_drain = 1'b0;
        o_serial_out_oe = ~state.sync2.cs_n & ~state.sdo_bit;
        o_ready_out = 1'b0;
        o_ready_oe = ~state.ready;
        o_low_power = state.low_power;
        o_wiper_setting_register = state.wiper;
    end
endmodule // serial_wiper_command_control

// >>> tb/wiper_ctrl_asserts.sv
`timescale 1ns/1ps
module wiper_ctrl_asserts
    import wiper_pkg::*;
#(
    parameter int CH = CHANNELS
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Serial link
    input wire logic i_serial_clk,
    input wire logic i_chip_select_n,
    input wire logic i_serial_in,
    input wire logic o_serial_out_open_drain,
    input wire logic o_serial_out_oe,
    // Control pins
    input wire logic i_preset_reload_pin_n,
    input wire logic i_write_protect_n,
    // Status pins
    input wire logic o_ready_out,
    input wire logic o_ready_oe,
    input wire logic o_low_power,
    // Wiper settings
    input wire logic [CH*WIPER_BITS-1:0] o_wiper_setting_register
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    chk_sdo_idle: assert property (
        i_chip_select_n [*4] |-> !o_serial_out_oe) else $error("serial out pulls while idle");
    chk_sdo_pull_low: assert property (
        o_serial_out_oe |-> o_serial_out_open_drain == 1'b0) else $error("serial out drives high");
    chk_ready_pull_low: assert property (
        o_ready_oe |-> o_ready_out == 1'b0) else $error("ready drives high");
    chk_preset_mid: assert property (
        (!i_preset_reload_pin_n) [*5] |-> o_wiper_setting_register == {CH{WIPER_MIDSCALE}})
        else $error("preset low did not force midscale");
    chk_wiper_on_rise: assert property (
        $changed(o_wiper_setting_register) |-> i_chip_select_n && $past(i_chip_select_n, 2))
        else $error("wiper changed while selected");
    chk_ready_cleared: assert property (
        $fell(i_chip_select_n) |-> ##[1:5] o_ready_oe) else $error("ready not cleared");
    chk_ready_preset: assert property (
        $rose(i_preset_reload_pin_n) |-> ##[1:8] !o_ready_oe) else $error("no ready after preset");
    chk_low_power_idle: assert property (
        $rose(o_low_power) |-> i_chip_select_n) else $error("low power entered mid frame");
endmodule // wiper_ctrl_asserts
bind serial_wiper_command_control wiper_ctrl_asserts #(.CH(CH)) i_wiper_ctrl_asserts (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_serial_clk(i_serial_clk),
    .i_chip_select_n(i_chip_select_n), .i_serial_in(i_serial_in),
    .o_serial_out_open_drain(o_serial_out_open_drain), .o_serial_out_oe(o_serial_out_oe),
    .i_preset_reload_pin_n(i_preset_reload_pin_n), .i_write_protect_n(i_write_protect_n),
    .o_ready_out(o_ready_out), .o_ready_oe(o_ready_oe), .o_low_power(o_low_power),
    .o_wiper_setting_register(o_wiper_setting_register));

// >>> tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Line from the device
    input wire logic i_serial_out_line,
    // Host pins
    output logic o_serial_clk,
    output logic o_chip_select_n,
    output logic o_serial_in
);
    logic mode3 = 1'b0;
    logic [15:0] rx = 16'h0000;
    initial begin
        o_serial_clk = 1'b0;
        o_chip_select_n = 1'b1;
        o_serial_in = 1'b0;
    end
    // Clock idles at polarity level; data changes on the falling edge
    task automatic frame(input logic [15:0] word, input int nbits);
        o_serial_clk = mode3;
        #62.5;
        o_chip_select_n = 1'b0;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            o_serial_clk = 1'b0;
            o_serial_in = word[15-i];
            #62.5;
            o_serial_clk = 1'b1;
            rx = {rx[14:0], i_serial_out_line};
            #62.5;
        end
        o_serial_clk = mode3;
        #62.5;
        o_chip_select_n = 1'b1;
        o_serial_in = ~o_serial_in;
        #125;
    endtask
endmodule // spi_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wiper_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
    typedef struct packed {logic [1:0] sel; logic [23:0] exp;} note_type;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_preset_reload_pin_n = 1'b1;
    logic i_write_protect_n = 1'b1;
    logic o_serial_out_open_drain, o_serial_out_oe, o_ready_out, o_ready_oe, o_low_power;
    logic [23:0] o_wiper_setting_register;
    wire logic sclk, csn, serial_in;
    wire logic sdo_line = o_serial_out_oe ? o_serial_out_open_drain : 1'b1;
    int fail_count = 0;
    int n_compared = 0;
    note_type notes[$];
    note_type cur;
    event chk_ev;
    logic [5:0] w[4];
    logic [7:0] st[4];
    initial forever #5 i_sys_clk = ~i_sys_clk;
    serial_wiper_command_control #(.SAVE_WAIT(20)) i_serial_wiper_command_control (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_serial_clk(sclk),
        .i_chip_select_n(csn), .i_serial_in(serial_in),
        .o_serial_out_open_drain(o_serial_out_open_drain), .o_serial_out_oe(o_serial_out_oe),
        .i_preset_reload_pin_n(i_preset_reload_pin_n), .i_write_protect_n(i_write_protect_n),
        .o_ready_out(o_ready_out), .o_ready_oe(o_ready_oe), .o_low_power(o_low_power),
        .o_wiper_setting_register(o_wiper_setting_register));
    spi_host_model i_spi_host_model (.i_serial_out_line(sdo_line), .o_serial_clk(sclk),
        .o_chip_select_n(csn), .o_serial_in(serial_in));
    function automatic logic [23:0] wvec();
        return {w[3], w[2], w[1], w[0]};
    endfunction
    function automatic logic [5:0] stepf(input logic [5:0] v, input logic [3:0] c);
        if (!c[1]) return c[3] ? (v[5] ? 6'h3F : {v[4:0], 1'b0}) : {1'b0, v[5:1]};
        if (c[3]) return (v == 6'h3F) ? v : v + 6'h01;
        return (v == 6'h00) ? v : v - 6'h01;
    endfunction
    task automatic note(input logic [1:0] sel, input logic [23:0] exp);
        notes.push_back('{sel, exp});
        ->chk_ev;
    endtask
    task automatic send(input logic [15:0] word, input int nbits = 16);
        @(negedge i_sys_clk);
        i_spi_host_model.frame(word, nbits);
        repeat (10) @(negedge i_sys_clk);
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 500 && o_ready_oe !== 1'b0; k++) @(negedge i_sys_clk);
        note(2'h3, 24'h1);
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(chk_ev) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.sel)
                2'h0: `CHK(o_wiper_setting_register, cur.exp)
                2'h1: `CHK({8'h00, i_spi_host_model.rx}, cur.exp)
                2'h2: `CHK({23'h0, o_low_power}, cur.exp)
                default: `CHK({23'h0, ~o_ready_oe}, cur.exp)
            endcase
        end
    end
    initial begin
        #800000;
        fail_count++;
        end_of_test();
    end
    initial begin : main
        logic [15:0] prev, word;
        logic [7:0] d;
        logic [3:0] c;
        logic [1:0] a;
        void'($urandom(32'hCEBA051F));
        repeat (20) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        for (int i = 0; i < 4; i++) begin
            w[i] = 6'h20;
            st[i] = 8'h20;
        end
        note(2'h0, wvec());
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            word = {CMD_WRITE_WIPER, 4'(i), d};
            i_spi_host_model.mode3 = i[0];
            send(word);
            w[i] = d[5:0];
            note(2'h0, wvec());
            if (i > 0) note(2'h1, {8'h00, prev});
            prev = word;
        end
        send({CMD_READ_WIPER, 4'h2, 8'h00});
        send({CMD_NOP, 12'h000});
        note(2'h1, {8'h00, CMD_READ_WIPER, 4'h2, 2'h0, w[2]});
        note(2'h2, 24'h1);
        for (int k = 0; k < 8; k++) begin
            c = 4'(k < 4 ? k + 12 : k);
            a = 2'($urandom);
            w[a] = c[3] ? 6'h3E : 6'h01;
            send({CMD_WRITE_WIPER, 2'h0, a, 2'h0, w[a]});
            send({c, 2'h0, a, 8'h00});
            for (int r = 0; r < 3; r++) begin
                if (r > 0) send(16'h0000, 0);
                for (int ch = 0; ch < 4; ch++) if (c[0] || ch == a) w[ch] = stepf(w[ch], c);
                note(2'h0, wvec());
            end
        end
        send({CMD_WRITE_WIPER, 4'h1, 8'h11});
        send({CMD_SAVE_ONE, 4'h1, 8'h00});
        wait_ready();
        st[1] = 8'h11;
        send({CMD_STORE_WRITE, 4'h3, 8'h07});
        wait_ready();
        st[3] = 8'h07;
        send({CMD_WRITE_WIPER, 4'h1, 8'h2A});
        send({CMD_RELOAD_ALL, 12'h000});
        for (int i = 0; i < 4; i++) w[i] = st[i][5:0];
        note(2'h0, wvec());
        send({CMD_READ_STORE, 4'h3, 8'h00});
        send({CMD_WRITE_WIPER, 4'h3, 8'h2A});
        w[3] = 6'h2A;
        note(2'h1, {8'h00, CMD_READ_STORE, 4'h3, 8'h07});
        i_write_protect_n = 1'b0;
        send({CMD_WRITE_WIPER, 4'h3, 8'h3F});
        send({CMD_INC_STEP_ALL, 12'h000});
        note(2'h0, wvec());
        send({CMD_RESTORE_ONE, 4'h3, 8'h00});
        w[3] = 6'h07;
        note(2'h0, wvec());
        send({CMD_NOP, 12'h000});
        i_write_protect_n = 1'b1;
        send({CMD_WRITE_WIPER, 4'h0, 8'h3F});
        w[0] = 6'h3F;
        note(2'h0, wvec());
        i_preset_reload_pin_n = 1'b0;
        repeat (10) @(negedge i_sys_clk);
        note(2'h0, {4{6'h20}});
        i_preset_reload_pin_n = 1'b1;
        wait_ready();
        for (int i = 0; i < 4; i++) w[i] = st[i][5:0];
        note(2'h0, wvec());
        end_of_test();
    end
endmodule // tb_top
